// file: hw/cmb_top.sv
// Configurable memory block: pseudo dual-port, single-port, FIFO and ternary CAM
`include "cmb_consts.svh"
module cmb_top (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      global_rst,
    input  wire logic                      local_rst,
    input  wire logic                      local_rst_inv,
    input  wire cmb_pkg::cmb_mode_t        mode,
    input  wire logic [`CMB_GLOBALS-1:0]   global_clock_nets,
    input  wire logic                      wclk_pin,
    input  wire logic [2:0]                wclk_sel,
    input  wire logic                      wclk_inv,
    input  wire logic                      write_side_clock_gate,
    input  wire logic                      port_clock_gate,
    input  wire logic [1:0]                wgate_sel,
    input  wire logic                      wgate_inv,
    input  wire logic                      rclk_pin,
    input  wire logic [2:0]                rclk_sel,
    input  wire logic                      rclk_inv,
    input  wire logic                      read_side_clock_gate,
    input  wire logic [1:0]                rgate_sel,
    input  wire logic                      rgate_inv,
    input  wire cmb_pkg::cmb_width_t       wr_width,
    input  wire cmb_pkg::cmb_width_t       rd_width,
    input  wire logic [`CMB_BIT_AW-1:0]    wr_addr,
    input  wire logic [`CMB_WORD_W-1:0]    wr_data,
    input  wire logic                      wr_cs,
    input  wire logic                      wr_en,
    input  wire logic [`CMB_BIT_AW-1:0]    rd_addr,
    input  wire logic                      rd_addr_reg,
    input  wire logic                      rd_data_reg,
    input  wire logic                      pop_strobe,
    input  wire logic                      fifo_rewind,
    input  wire logic                      show_ahead,
    input  wire logic [`CMB_LEVEL_W-1:0]   full_level,
    input  wire logic [`CMB_LEVEL_W-1:0]   afull_level,
    input  wire logic [`CMB_LEVEL_W-1:0]   aempty_level,
    input  wire logic [`CMB_CAM_W-1:0]     cam_data,
    input  wire logic                      cam_dont_care,
    input  wire logic                      cam_mask_enable,
    input  wire logic                      cam_mask_load,
    input  wire logic                      cam_out_reg,
    output logic      [`CMB_WORD_W-1:0]    rd_data,
    output logic                           fifo_full,
    output logic                           fifo_afull,
    output logic                           fifo_empty,
    output logic                           fifo_aempty,
    output logic                           cam_match,
    output logic                           cam_multi,
    output logic      [`CMB_CAM_AW-1:0]    cam_addr
);
    import cmb_pkg::*;

    typedef struct packed {
        logic [`CMB_BIT_AW-1:0]                         wa;
        logic [`CMB_WORD_W-1:0]                         wd;
        logic                                           wpend;
        logic                                           wdone;
        logic [`CMB_BIT_AW-1:0]                         ra;
        logic [`CMB_WORD_OFF_W-1:0]                     roff;
        logic [`CMB_WORD_W-1:0]                         rd_data;
        logic [`CMB_BIT_AW-1:0]                         wptr;
        logic [`CMB_BIT_AW-1:0]                         rptr;
        logic [`CMB_LEVEL_W-1:0]                        wlevel;
        logic [`CMB_LEVEL_W-1:0]                        rlevel;
        logic                                           full;
        logic                                           afull;
        logic                                           empty;
        logic                                           aempty;
        logic [`CMB_CAM_W-1:0]                          cam_d;
        logic [`CMB_CAM_AW-1:0]                         cam_a;
        logic                                           cam_we;
        logic                                           cam_dc;
        logic                                           cam_men;
        logic                                           cam_pend;
        logic [`CMB_CAM_W-1:0]                          cam_mask;
        logic [`CMB_CAM_ENTRIES-1:0][`CMB_CAM_W-1:0]    cam_val;
        logic [`CMB_CAM_ENTRIES-1:0][`CMB_CAM_W-1:0]    cam_care;
        logic                                           cam_match;
        logic                                           cam_multi;
        logic [`CMB_CAM_AW-1:0]                         cam_addr;
    } cmb_st_t;

    cmb_st_t                         s;
    cmb_st_t                         next_s;
    logic                            arst_n;
    logic                            wtick;
    logic                            rtick;
    logic                            wgate_local;
    logic                            rgate_local;
    logic [`CMB_WORD_W-1:0]          mem_rdata;
    logic                            mem_we;
    logic [`CMB_WORD_AW-1:0]         mem_waddr;
    logic [`CMB_WORD_W-1:0]          mem_wdata;
    logic [`CMB_WORD_W-1:0]          mem_wbits;
    logic [`CMB_BIT_AW-1:0]          rbit;
    logic [`CMB_LEVEL_W-1:0]         wbits_n;
    logic [`CMB_LEVEL_W-1:0]         rbits_n;
    logic [`CMB_WORD_W-1:0]          rd_word;
    logic [`CMB_BIT_AW-1:0]          wr_bit;
    logic [`CMB_BIT_AW-1:0]          rd_bit;
    logic                            push;
    logic                            pop;
    logic [`CMB_CAM_W-1:0]           cmp_mask;
    logic [`CMB_CAM_ENTRIES-1:0]     hits;
    logic [`CMB_CAM_AW-1:0]          lowest;

    // Reset from logic is glitch sensitive; user keeps it clean
    assign arst_n = rstn & ~(global_rst | (local_rst ^ local_rst_inv));

    // The write group also serves the single port and the CAM
    always_comb begin
        case (mode)
            MODE_FIFO: wgate_local = wr_en;
            MODE_PDP:  wgate_local = write_side_clock_gate;
            default:   wgate_local = port_clock_gate;
        endcase
        rgate_local = (mode == MODE_FIFO) ? pop_strobe : read_side_clock_gate;
    end

    cmb_sel u_wsel (
        .clk               (clk),
        .arst_n            (arst_n),
        .clk_pin           (wclk_pin),
        .global_clock_nets (global_clock_nets),
        .clk_sel           (wclk_sel),
        .clk_inv           (wclk_inv),
        .local_gate        (wgate_local),
        .gate_sel          (wgate_sel),
        .gate_inv          (wgate_inv),
        .tick              (wtick)
    );

    cmb_sel u_rsel (
        .clk               (clk),
        .arst_n            (arst_n),
        .clk_pin           (rclk_pin),
        .global_clock_nets (global_clock_nets),
        .clk_sel           (rclk_sel),
        .clk_inv           (rclk_inv),
        .local_gate        (rgate_local),
        .gate_sel          (rgate_sel),
        .gate_inv          (rgate_inv),
        .tick              (rtick)
    );

    cmb_mem #(
        .WIDTH (`CMB_WORD_W),
        .DEPTH (`CMB_DEPTH),
        .AW    (`CMB_WORD_AW)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .wbits (mem_wbits),
        .raddr (rbit[`CMB_BIT_AW-1:`CMB_WORD_OFF_W]),
        .rdata (mem_rdata)
    );

    // Word index times width gives the bit address, so narrow words
    // fill a memory word from bit zero upward on every port
    assign wbits_n = cmb_width_bits(wr_width);
    assign rbits_n = cmb_width_bits(rd_width);
    assign wr_bit  = `CMB_BIT_AW'(wr_addr << wr_width);
    assign rd_bit  = `CMB_BIT_AW'(rd_addr << rd_width);

    // Committed write of the registered write group
    assign mem_we    = s.wpend && (mode != MODE_CAM);
    assign mem_waddr = s.wa[`CMB_BIT_AW-1:`CMB_WORD_OFF_W];
    assign mem_wdata = s.wd << s.wa[`CMB_WORD_OFF_W-1:0];
    assign mem_wbits = cmb_width_mask(wr_width) << s.wa[`CMB_WORD_OFF_W-1:0];

    always_comb begin
        case (mode)
            MODE_PDP:  rbit = rd_addr_reg ? s.ra : rd_bit;
            MODE_SP:   rbit = s.wa;
            MODE_FIFO: rbit = s.rptr;
            default:   rbit = '0;
        endcase
    end

    // Read data of the address presented one cycle earlier
    assign rd_word = (mem_rdata >> s.roff) & cmb_width_mask(rd_width);

    // FIFO occupancy guards use live levels so a stale flag never lets
    // a pointer overrun the array
    assign push = (mode == MODE_FIFO) && wtick
                  && (`CMB_LEVEL_W'(s.wlevel + wbits_n) <= full_level);
    assign pop  = (mode == MODE_FIFO) && rtick && (s.rlevel >= rbits_n);

    // Ternary compare: a bit takes part only where it cares and is unmasked
    assign cmp_mask = s.cam_men ? s.cam_mask : '0;

    generate
        for (genvar i = 0; i < `CMB_CAM_ENTRIES; i++) begin : g_hit
            assign hits[i] = &(~(s.cam_val[i] ^ s.cam_d) | ~(s.cam_care[i] & ~cmp_mask));
        end
    endgenerate

    always_comb begin
        lowest = '0;
        for (int i = `CMB_CAM_ENTRIES - 1; i >= 0; i--) begin
            if (hits[i]) begin
                lowest = `CMB_CAM_AW'(i);
            end
        end
    end

    always_comb begin
        logic [`CMB_LEVEL_W-1:0] wl;
        logic [`CMB_LEVEL_W-1:0] rl;
        logic [`CMB_CAM_W-1:0]   keep;
        wl     = s.wlevel;
        rl     = s.rlevel;
        keep   = '0;
        next_s = s;
        next_s.wpend = 1'b0;
        next_s.wdone = s.wpend;
        next_s.roff  = rbit[`CMB_WORD_OFF_W-1:0];
        next_s.cam_pend = 1'b0;

        case (mode)
            MODE_PDP, MODE_SP: begin
                if (wtick) begin
                    next_s.wa    = wr_bit;
                    next_s.wd    = wr_data;
                    next_s.wpend = wr_cs & wr_en;
                end
                if (mode == MODE_PDP) begin
                    if (rtick) begin
                        next_s.ra = rd_bit;
                    end
                    if (rtick || !rd_data_reg) begin
                        next_s.rd_data = rd_word;
                    end
                end else if ((wtick && wr_cs) || !rd_data_reg) begin
                    next_s.rd_data = rd_word;
                end
            end

            MODE_FIFO: begin
                if (push) begin
                    next_s.wa    = s.wptr;
                    next_s.wd    = wr_data;
                    next_s.wpend = 1'b1;
                    next_s.wptr  = `CMB_BIT_AW'(s.wptr + wbits_n);
                    wl           = `CMB_LEVEL_W'(wl + wbits_n);
                end
                // Readers see a word only once it has reached the array
                if (s.wdone) begin
                    rl = `CMB_LEVEL_W'(rl + wbits_n);
                end
                if (pop) begin
                    next_s.rptr = `CMB_BIT_AW'(s.rptr + rbits_n);
                    wl          = `CMB_LEVEL_W'(wl - rbits_n);
                    rl          = `CMB_LEVEL_W'(rl - rbits_n);
                    if (!show_ahead) begin
                        next_s.rd_data = rd_word;
                    end
                end
                if (show_ahead) begin
                    next_s.rd_data = rd_word;
                end
                // Rewind assumes no write is in flight; data is untouched
                if (fifo_rewind) begin
                    next_s.rptr = '0;
                    wl          = {1'b0, next_s.wptr};
                    rl          = {1'b0, next_s.wptr};
                end
                next_s.wlevel = wl;
                next_s.rlevel = rl;
                if (wtick) begin
                    next_s.full  = `CMB_LEVEL_W'(wl + wbits_n) > full_level;
                    next_s.afull = wl >= afull_level;
                end
                if (rtick) begin
                    next_s.empty  = rl < rbits_n;
                    next_s.aempty = rl <= aempty_level;
                end
            end

            MODE_CAM: begin
                if (wtick) begin
                    next_s.cam_d    = cam_data;
                    next_s.cam_a    = wr_addr[`CMB_CAM_AW-1:0];
                    next_s.cam_we   = wr_en;
                    next_s.cam_dc   = cam_dont_care;
                    // Sampled at the tick and held in cam_men until the next write-group tick
                    next_s.cam_men  = cam_mask_enable;
                    next_s.cam_pend = wr_cs;
                    if (cam_mask_load) begin
                        next_s.cam_mask = cam_data;
                    end
                end
                if (s.cam_pend && s.cam_we) begin
                    keep = cmp_mask;
                    next_s.cam_val[s.cam_a] = (s.cam_val[s.cam_a] & keep)
                                              | (s.cam_d & ~keep);
                    next_s.cam_care[s.cam_a] = (s.cam_care[s.cam_a] & keep)
                                               | ({`CMB_CAM_W{~s.cam_dc}} & ~keep);
                end
                if (!cam_out_reg || (s.cam_pend && !s.cam_we)) begin
                    next_s.cam_match = |hits;
                    next_s.cam_multi = |(hits & (hits - 1'b1));
                    next_s.cam_addr  = lowest;
                end
            end

            default: begin
                next_s = s;
            end
        endcase
    end

    // The CAM array and FIFO pointers clear with the memory reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data     = s.rd_data;
    assign fifo_full   = s.full;
    assign fifo_afull  = s.afull;
    assign fifo_empty  = s.empty;
    assign fifo_aempty = s.aempty;
    assign cam_match   = s.cam_match;
    assign cam_multi   = s.cam_multi;
    assign cam_addr    = s.cam_addr;

endmodule

// file: hw/cmb_consts.svh
// Constants of the configurable memory block
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

`define CMB_ARRAY_BITS   16384
`define CMB_BIT_AW       14
`define CMB_LEVEL_W      15
`define CMB_WORD_W       32
`define CMB_WORD_OFF_W   5
`define CMB_DEPTH        512
`define CMB_WORD_AW      9
`define CMB_CAM_ENTRIES  128
`define CMB_CAM_W        48
`define CMB_CAM_AW       7
`define CMB_WIDTH_MAX    3'h5
`define CMB_CLK_LOCAL    3'h0
`define CMB_EN_LOCAL     2'h0
`define CMB_EN_GLOBAL1   2'h1
`define CMB_EN_GLOBAL2   2'h2
`define CMB_GLOBALS      4

`endif

// file: hw/cmb_pkg.sv
// Types and width helpers of the configurable memory block
`include "cmb_consts.svh"

package cmb_pkg;

    typedef enum logic [1:0] {
        MODE_PDP,
        MODE_SP,
        MODE_FIFO,
        MODE_CAM
    } cmb_mode_t;

    typedef logic [2:0] cmb_width_t;

    // Port width in bits for a width code 0..5
    function automatic logic [`CMB_LEVEL_W-1:0] cmb_width_bits(input cmb_width_t code);
        cmb_width_bits = `CMB_LEVEL_W'(6'h01 << code);
    endfunction

    function automatic logic [`CMB_WORD_W-1:0] cmb_width_mask(input cmb_width_t code);
        logic [`CMB_LEVEL_W-1:0] n;
        n = cmb_width_bits(code);
        for (int i = 0; i < `CMB_WORD_W; i++) begin
            cmb_width_mask[i] = (i < int'(n));
        end
    endfunction

endpackage

// file: hw/cmb_mem.sv
// Bit-maskable word array with registered read data
`include "cmb_consts.svh"
module cmb_mem #(
    parameter int WIDTH = `CMB_WORD_W,
    parameter int DEPTH = `CMB_DEPTH,
    parameter int AW    = `CMB_WORD_AW
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] wbits,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    import cmb_pkg::*;

    logic [WIDTH-1:0] mem [DEPTH];

    // Array holds no reset so it maps onto block memory
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= (mem[waddr] & ~wbits) | (wdata & wbits);
        end
        rdata <= mem[raddr];
    end

endmodule

// file: hw/cmb_sel.sv
// Clock and clock-enable source selection turned into a one-cycle tick
`include "cmb_consts.svh"
module cmb_sel (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   clk_pin,
    input  wire logic [`CMB_GLOBALS-1:0] global_clock_nets,
    input  wire logic [2:0]             clk_sel,
    input  wire logic                   clk_inv,
    input  wire logic                   local_gate,
    input  wire logic [1:0]             gate_sel,
    input  wire logic                   gate_inv,
    output logic                        tick
);
    import cmb_pkg::*;

    typedef struct packed {
        logic [`CMB_GLOBALS:0] meta;
        logic [`CMB_GLOBALS:0] sync;
        logic                  prev;
    } cmb_sel_st_t;

    cmb_sel_st_t s;
    cmb_sel_st_t next_s;
    logic        clk_now;
    logic        gate_now;

    always_comb begin
        next_s      = s;
        next_s.meta = {global_clock_nets, clk_pin};
        next_s.sync = s.meta;
        // Index 0 is the local clock, 1..4 the global nets
        clk_now     = (clk_sel > 3'(`CMB_GLOBALS)) ? 1'b0 : s.sync[clk_sel];
        // Raw level kept so an inverted clock shows no edge after reset
        next_s.prev = clk_now;
        case (gate_sel)
            `CMB_EN_GLOBAL1: gate_now = s.sync[2];
            `CMB_EN_GLOBAL2: gate_now = s.sync[3];
            default:         gate_now = local_gate;
        endcase
        gate_now = gate_now ^ gate_inv;
        // Rising edge of the selected source (falling edge when clk_inv is set), gated by the enable
        tick = (clk_now ^ s.prev) & (clk_now ^ clk_inv) & gate_now;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

// file: bench/cmb_assertions.sv
// Port checker of the configurable memory block
module cmb_assertions
    import cmb_pkg::*;
(
    input logic        clk,
    input logic        rstn,
    input logic        global_rst,
    input logic        local_rst,
    input logic        local_rst_inv,
    input cmb_mode_t   mode,
    input logic [1:0]  wgate_sel,
    input logic        wgate_inv,
    input logic [1:0]  rgate_sel,
    input logic        rgate_inv,
    input logic        wr_en,
    input logic        wr_cs,
    input logic        pop_strobe,
    input logic [14:0] full_level,
    input logic [14:0] afull_level,
    input logic [14:0] aempty_level,
    input cmb_width_t  wr_width,
    input cmb_width_t  rd_width,
    input logic        cam_out_reg,
    input logic [31:0] rd_data,
    input logic        fifo_full,
    input logic        fifo_afull,
    input logic        fifo_empty,
    input logic        fifo_aempty,
    input logic        cam_match,
    input logic        cam_multi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rst_any;
    logic wloc;
    logic rloc;
    assign rst_any = !rstn | global_rst | (local_rst ^ local_rst_inv);
    // Gate selects 0 and 3 both take the local gate, so only then is the cause visible here
    assign wloc = !(^wgate_sel) && !wgate_inv;
    assign rloc = mode == MODE_FIFO && !(^rgate_sel) && !rgate_inv;
    default clocking @(posedge clk); endclocking
    default disable iff (rst_any);
    chk_reset_clears:
    assert property (disable iff (1'b0) rst_any |-> !fifo_full && !fifo_empty && !cam_match
        && rd_data == 32'h0) else $error("outputs not cleared in reset");
    chk_multi_match:
    assert property (cam_multi |-> cam_match) else $error("multi-match without match");
    chk_full_gate:
    assert property (mode == MODE_FIFO && wloc && $changed(fifo_full) |-> $past(wr_en)
        || $past(wr_en, 2)) else $error("full moved without write enable");
    chk_afull_gate:
    assert property (mode == MODE_FIFO && wloc && $changed(fifo_afull) |-> $past(wr_en)
        || $past(wr_en, 2)) else $error("almost full moved without write enable");
    chk_empty_gate:
    assert property (rloc && $changed(fifo_empty) |-> $past(pop_strobe)
        || $past(pop_strobe, 2)) else $error("empty moved without read enable");
    chk_aempty_gate:
    assert property (rloc && $changed(fifo_aempty) |-> $past(pop_strobe)
        || $past(pop_strobe, 2)) else $error("almost empty moved without read enable");
    chk_full_afull:
    assert property (mode == MODE_FIFO && fifo_full
        && afull_level + (15'h1 << wr_width) <= full_level |-> fifo_afull)
        else $error("full without almost full");
    chk_empty_aempty:
    assert property (mode == MODE_FIFO && fifo_empty
        && aempty_level + 15'h1 >= (15'h1 << rd_width) |-> fifo_aempty)
        else $error("empty without almost empty");
    chk_cam_cause:
    assert property (mode == MODE_CAM && cam_out_reg && wloc && $changed(cam_match)
        |-> $past(wr_cs) || $past(wr_cs, 2) || $past(wr_cs, 3) || $past(wr_cs, 4))
        else $error("match moved without a selected operation");
endmodule

bind cmb_top cmb_assertions cmb_assertions_i (.*);

// file: bench/cmb_user.sv
// Far-side user logic: one local clock pulse per request
module cmb_user (
    input logic  clk,
    input logic  req,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    always @(posedge clk) begin
        cnt <= req ? cnt + 4'h1 : 4'h0;
    end
    // Pin stands low outside requests so no stray edge makes a tick
    assign pin = req && cnt < 4'h4;
endmodule

// file: bench/tb_top.sv
// Self-checking bench of the configurable memory block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cmb_pkg::*;
    logic clk, rstn, global_rst, local_rst, local_rst_inv, pin, req, gate, inv;
    logic wclk_inv, rclk_inv, wgate_inv, rgate_inv, rd_addr_reg, rd_data_reg;
    logic wr_cs, wr_en, pop_strobe, fifo_rewind, show_ahead, cam_dont_care;
    logic cam_mask_enable, cam_mask_load, cam_out_reg, cam_match, cam_multi;
    logic fifo_full, fifo_afull, fifo_empty, fifo_aempty;
    logic [1:0] wgate_sel, rgate_sel;
    logic [2:0] wclk_sel, rclk_sel;
    logic [3:0] global_clock_nets;
    logic [6:0] cam_addr;
    logic [13:0] wr_addr, rd_addr;
    logic [14:0] full_level, afull_level, aempty_level;
    logic [31:0] wr_data, rd_data;
    logic [47:0] cam_data, x, cm;
    logic [47:0] cv[128];
    logic [47:0] cc[128];
    cmb_mode_t mode;
    cmb_width_t wr_width, rd_width;
    int fails = 0, n_compared = 0, cyc = 0, b, d;
    logic [31:0] mem[512];
    int a[4];
    logic [31:0] q[$], all[$];
    assign global_clock_nets = {4{pin}};
    cmb_top cmb_top_i (.*, .wclk_pin(pin), .rclk_pin(pin), .write_side_clock_gate(gate),
        .port_clock_gate(gate), .read_side_clock_gate(gate));
    cmb_user cmb_user_i (.clk(clk), .req(req), .pin(pin));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fails++;
            give_verdict();
        end
    end
    // Inputs stay put for the whole pulse, whichever pin edge makes the tick
    task automatic op();
        req <= 1'b1;
        gate <= 1'b1;
        repeat (8) @(posedge clk);
        req <= 1'b0;
        gate <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // The first three tests reset through different sources, the CAM test through rstn again, with random clock choices
    task automatic restart(input cmb_mode_t m, input int k);
        inv = 1'($urandom);
        mode <= m;
        {wclk_sel, rclk_sel} <= {3'($urandom % 5), 3'($urandom % 5)};
        {wclk_inv, rclk_inv} <= 2'($urandom);
        {wgate_sel, rgate_sel} <= {{2{1'($urandom)}}, {2{1'($urandom)}}};
        local_rst_inv <= inv;
        local_rst <= (k == 2) ? !inv : inv;
        rstn <= (k != 0);
        global_rst <= (k == 1);
        repeat (3) @(posedge clk);
        {rstn, global_rst, local_rst} <= {2'h2, inv};
        repeat (4) @(posedge clk);
    endtask
    task automatic camw(input int i, input logic [47:0] v, input logic dc);
        wr_addr <= 14'(i);
        cam_data <= v;
        cam_dont_care <= dc;
        wr_en <= 1'b1;
        cv[i] = (cv[i] & cm) | (v & ~cm);
        cc[i] = (cc[i] & cm) | ({48{!dc}} & ~cm);
        op();
    endtask
    task automatic camc(input logic [47:0] v);
        int hit, n;
        n = 0;
        wr_en <= 1'b0;
        cam_data <= v;
        op();
        for (int i = 127; i >= 0; i--) begin
            if (((cv[i] ^ v) & cc[i] & ~cm) == 48'h0) begin
                hit = i;
                n++;
            end
        end
        check(cam_match, n > 0);
        check(cam_multi, n > 1);
        if (n > 0) check(cam_addr, 48'(hit));
    endtask
    initial begin
        {rstn, global_rst, local_rst, local_rst_inv, req, gate, wclk_sel, rclk_sel} = '0;
        {wclk_inv, rclk_inv, wgate_sel, rgate_sel, wgate_inv, rgate_inv, wr_width} = '0;
        {rd_width, wr_addr, rd_addr, wr_data, wr_cs, wr_en, rd_addr_reg, rd_data_reg} = '0;
        {pop_strobe, fifo_rewind, show_ahead, full_level, afull_level, aempty_level} = '0;
        {cam_data, cam_dont_care, cam_mask_enable, cam_mask_load, cam_out_reg, cm} = '0;
        mode = MODE_PDP;
        void'($urandom(56));
        repeat (17) @(posedge clk);
        restart(MODE_PDP, 0);
        {wr_width, rd_width, wr_cs, wr_en} <= {3'h5, 3'h3, 2'h3};
        for (int i = 0; i < 4; i++) begin
            a[i] = $urandom % 512;
            mem[a[i]] = $urandom;
            wr_addr <= 14'(a[i]);
            wr_data <= mem[a[i]];
            op();
        end
        for (int i = 0; i < 4; i++) begin
            b = $urandom % 4;
            rd_addr <= 14'(a[i] * 4 + b);
            repeat (3) @(posedge clk);
            check(rd_data, 48'((mem[a[i]] >> (8 * b)) & 255));
        end
        $display("pseudo dual-port test done");
        restart(MODE_SP, 1);
        {rd_width, wr_cs, wr_en, wr_data} <= {3'h5, 2'h1, 32'($urandom)};
        op();
        wr_en <= 1'b0;
        wr_cs <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr_addr <= 14'(a[i]);
            op();
            check(rd_data, 48'(mem[a[i]]));
        end
        $display("single-port test done");
        restart(MODE_FIFO, 2);
        {full_level, afull_level, aempty_level, wr_en} <= {15'h080, 15'h060, 15'h020, 1'b1};
        for (int i = 0; i < 5; i++) begin
            d = $urandom;
            wr_data <= d;
            op();
            if (q.size() < 4) q.push_back(d);
            all = q;
            check(fifo_full, q.size() * 32 + 32 > 128);
            check(fifo_afull, q.size() * 32 >= 96);
        end
        {wr_en, pop_strobe} <= 2'h1;
        for (int i = 0; i < 5; i++) begin
            op();
            if (q.size() > 0) check(rd_data, 48'(q.pop_front()));
            check(fifo_empty, q.size() == 0);
            check(fifo_aempty, q.size() * 32 <= 32);
        end
        {pop_strobe, fifo_rewind} <= 2'h1;
        @(posedge clk);
        {pop_strobe, fifo_rewind} <= 2'h2;
        op();
        check(rd_data, 48'(all[0]));
        {pop_strobe, show_ahead} <= 2'h1;
        repeat (3) @(posedge clk);
        check(rd_data, 48'(all[1]));
        $display("fifo test done");
        restart(MODE_CAM, 0);
        {cam_out_reg, wr_cs} <= 2'h3;
        for (int i = 0; i < 128; i++) camw(i, 48'(i) + 48'h100, 1'b0);
        x = {16'h8000 | 16'($urandom), 32'($urandom)};
        camw(70, x, 1'b0);
        camw(40, x, 1'b0);
        camc(x);
        camc(48'h103);
        camc(48'h7FFF_0000_0000);
        camw(100, 48'h0, 1'b1);
        camc(48'h7FFF_0000_0000);
        {cam_mask_load, wr_cs, cam_data} <= {2'h2, 48'h1};
        op();
        {cam_mask_load, wr_cs, cam_mask_enable} <= 3'h3;
        cm = 48'h1;
        camc(48'h103);
        camw(3, 48'h0, 1'b0);
        cam_mask_enable <= 1'b0;
        cm = 48'h0;
        camc(48'h1);
        $display("cam test done");
        give_verdict();
    end
endmodule
